// file: design/scan_trigger_sequencer.sv
`timescale 1ns/1ps
// Notes on behaviour
// - In idle the armed output stays low.
// - Step key or bus initiate leaves idle, enters arm layer, raises armed.
// - Immediate arm spacing passes straight through to the scan layer.
// - Event arm spacing waits for step, bus trigger, external or link input.
// - Arm count 1 to 9999 or infinite; return to arm while arms remain.
// - Immediate scan spacing goes on at once; others wait for their event.
// - Timer scan spacing: first scan immediate, later ones wait on timer.
// - Interval timer spans 1 ms to 99999.999 s in milliseconds.
// - Scan count per arm is 1 to 9999 or infinite.
// - Immediate channel spacing scans at once; others wait per channel.
// - Timer channel spacing: first channel immediate, rest wait on timer.
// - Channel count follows list length or a programmed 1 to 9999 or inf.
// - Each slot has its own settle delay after every closure there.
// - Immediate start closes the first channel at once, then steps on delay.
// - Scan interval runs from one scan start to the next.
// - Open-all aborts any scan, opens all relays, returns to idle.
// - One simulator code gives 40 channels, the other a 4 by 10 matrix.
// - Type assignment refused on a slot holding an identified card.
// - Each advance opens the old channel before closing the next.
// - With infinite count the walk wraps to the first list entry.
// - Type change that strands list channels clears the scan list.
module scan_trigger_sequencer #(
	parameter logic [15:0] TICK_CYCLES = scan_seq_pkg::TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic stepKey,
	input wire logic extTrigIn,
	input wire logic trigBusIn,
	input wire logic [1:0] cardPresent,
	input wire logic busInit,
	input wire logic busTrig,
	input wire logic openAll,
	input wire scan_seq_pkg::spacing_e armSpacing,
	input wire scan_seq_pkg::spacing_e scanSpacing,
	input wire scan_seq_pkg::spacing_e chanSpacing,
	input wire logic [13:0] armCount,
	input wire logic [13:0] scanCount,
	input wire logic [13:0] chanCount,
	input wire logic chanCountAuto,
	input wire logic [26:0] scanIntervalMs,
	input wire logic [26:0] chanIntervalMs,
	input wire logic [26:0] settleMs0,
	input wire logic [26:0] settleMs1,
	input wire logic scanListWr,
	input wire logic [79:0] scanListData,
	input wire logic typeWr,
	input wire logic typeSlot,
	input wire logic [15:0] typeCode,
	output logic armed,
	output logic settling,
	output logic [79:0] relayClose,
	output logic [6:0] activeChan,
	output logic [79:0] scanListQ,
	output scan_seq_pkg::slot_kind_e slot0Kind,
	output scan_seq_pkg::slot_kind_e slot1Kind,
	output logic typeRefused
);
	typedef struct packed {
		scan_seq_pkg::state_e st;
		logic [13:0] armLeft;
		logic [13:0] scanLeft;
		logic [13:0] chanLeft;
		logic firstScan;
		logic firstChan;
		logic [6:0] cur;
		logic curValid;
		logic [79:0] relays;
		logic [79:0] scanList;
		scan_seq_pkg::slot_kind_e kind0;
		scan_seq_pkg::slot_kind_e kind1;
		logic refused;
		logic [15:0] tickCnt;
		logic tick;
	} seq_s;

	seq_s s_reg;
	seq_s s_next;

	logic [4:0] pinLevel;
	logic [4:0] pinRise;
	logic stepRise;
	logic extRise;
	logic linkRise;
	logic scanTmrDone;
	logic chanTmrDone;
	logic settleDone;
	logic scanLoad;
	logic chanLoad;
	logic settleLoad;
	logic [26:0] settleVal;
	logic [6:0] nextIdx;
	logic nextValid;
	logic [13:0] listLen;
	logic armGo;
	logic scanGo;
	logic chanGo;
	scan_seq_pkg::slot_kind_e newKind;

	// All rear-panel and key inputs pass two flops first
	pin_sync #(.W(5)) uPins (
		.mclk(mclk),
		.rstn(rstn),
		.din({cardPresent, trigBusIn, extTrigIn, stepKey}),
		.level(pinLevel),
		.rise(pinRise)
	);
	assign stepRise = pinRise[0];
	assign extRise = pinRise[1];
	assign linkRise = pinRise[2];

	// Three delay counters on the shared tick
	ms_down_timer uScanTmr (
		.mclk(mclk),
		.rstn(rstn),
		.tick(s_reg.tick),
		.load(scanLoad),
		.loadVal(scanIntervalMs),
		.done(scanTmrDone)
	);
	ms_down_timer uChanTmr (
		.mclk(mclk),
		.rstn(rstn),
		.tick(s_reg.tick),
		.load(chanLoad),
		.loadVal(chanIntervalMs),
		.done(chanTmrDone)
	);
	ms_down_timer uSettleTmr (
		.mclk(mclk),
		.rstn(rstn),
		.tick(s_reg.tick),
		.load(settleLoad),
		.loadVal(settleVal),
		.done(settleDone)
	);

	// Spacing event select; an unknown code behaves as hold
	function automatic logic spacingEvt(scan_seq_pkg::spacing_e sp,
			logic tmr);
		logic hit;
		hit = 1'b0;
		unique case (sp)
			scan_seq_pkg::SP_IMMEDIATE: hit = 1'b1;
			scan_seq_pkg::SP_TIMER: hit = tmr;
			scan_seq_pkg::SP_EXTERNAL: hit = extRise;
			scan_seq_pkg::SP_BUS: hit = busTrig;
			scan_seq_pkg::SP_MANUAL: hit = stepRise;
			scan_seq_pkg::trigger_bus_input_spacing: hit = linkRise;
			scan_seq_pkg::SP_HOLD: hit = 1'b0;
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// A process, so event pins read inside the function wake it up
	always_comb begin
		// Arm layer has no timer source, so timer passes like immediate
		armGo = spacingEvt(armSpacing, 1'b1);
		// First scan and first channel skip the timer wait
		scanGo = spacingEvt(scanSpacing,
			scanTmrDone | s_reg.firstScan);
		chanGo = spacingEvt(chanSpacing,
			chanTmrDone | s_reg.firstChan);
	end

	// Next list entry after the current one, wrapping at the end
	always_comb begin
		int start;
		int j;
		start = s_reg.curValid ? int'(s_reg.cur) + 1 : 0;
		j = 0;
		nextIdx = scan_seq_pkg::IDX_RESET;
		nextValid = 1'b0;
		for (int i = scan_seq_pkg::NUM_CH - 1; i >= 0; i--) begin
			j = start + i;
			if (j >= scan_seq_pkg::NUM_CH) begin
				j = j - scan_seq_pkg::NUM_CH;
			end
			if (s_reg.scanList[j]) begin
				nextIdx = 7'(j);
				nextValid = 1'b1;
			end
		end
	end

	// List length for the automatic channel count
	always_comb begin
		listLen = scan_seq_pkg::COUNT_INF;
		for (int i = 0; i < scan_seq_pkg::NUM_CH; i++) begin
			listLen = listLen + 14'(s_reg.scanList[i]);
		end
	end

	// Settle time follows the slot of the channel being closed
	assign settleVal = (nextIdx >= scan_seq_pkg::SLOT1_BASE) ?
		settleMs1 : settleMs0;

	// Simulator and card codes map onto slot kinds
	always_comb begin
		if (typeCode == scan_seq_pkg::TYPE_EMPTY) begin
			newKind = scan_seq_pkg::SLOT_EMPTY;
		end else if (typeCode == scan_seq_pkg::TYPE_SIM_MUX) begin
			newKind = scan_seq_pkg::SLOT_MUX;
		end else if (typeCode == scan_seq_pkg::TYPE_SIM_MATRIX) begin
			newKind = scan_seq_pkg::SLOT_MATRIX;
		end else begin
			newKind = scan_seq_pkg::SLOT_OTHER;
		end
	end

	// Sequencer, tick divider and slot configuration
	always_comb begin
		s_next = s_reg;
		s_next.refused = 1'b0;
		scanLoad = 1'b0;
		chanLoad = 1'b0;
		settleLoad = 1'b0;

		// One-millisecond tick from the system clock
		if (s_reg.tickCnt >= TICK_CYCLES - 16'h0001) begin
			s_next.tickCnt = 16'h0000;
			s_next.tick = 1'b1;
		end else begin
			s_next.tickCnt = s_reg.tickCnt + 16'h0001;
			s_next.tick = 1'b0;
		end

		if (scanListWr) begin
			s_next.scanList = scanListData;
		end

		// Identified cards own their slot; assignment is refused
		if (typeWr) begin
			if (pinLevel[3 + int'(typeSlot)]) begin
				s_next.refused = 1'b1;
			end else if (!typeSlot) begin
				s_next.kind0 = newKind;
				if (newKind == scan_seq_pkg::SLOT_EMPTY &&
						s_reg.scanList[39:0] != '0) begin
					s_next.scanList = '0;
				end
			end else begin
				s_next.kind1 = newKind;
				if (newKind == scan_seq_pkg::SLOT_EMPTY &&
						s_reg.scanList[79:40] != '0) begin
					s_next.scanList = '0;
				end
			end
		end

		unique case (s_reg.st)
			scan_seq_pkg::ST_IDLE: begin
				if (stepRise || busInit) begin
					s_next.st = scan_seq_pkg::ST_ARM;
					s_next.armLeft = armCount;
					s_next.curValid = 1'b0;
				end
			end
			scan_seq_pkg::ST_ARM: begin
				if (armGo) begin
					s_next.st = scan_seq_pkg::ST_SCAN;
					s_next.scanLeft = scanCount;
					s_next.firstScan = 1'b1;
				end
			end
			scan_seq_pkg::ST_SCAN: begin
				if (scanGo) begin
					// Interval restarts at each scan start
					scanLoad = 1'b1;
					s_next.firstScan = 1'b0;
					s_next.firstChan = 1'b1;
					s_next.st = scan_seq_pkg::ST_CHAN;
					s_next.chanLeft = chanCountAuto ?
						listLen : chanCount;
				end
			end
			scan_seq_pkg::ST_CHAN: begin
				if (chanGo) begin
					chanLoad = 1'b1;
					s_next.firstChan = 1'b0;
					s_next.relays = '0;
					s_next.st = scan_seq_pkg::ST_BREAK;
				end
			end
			scan_seq_pkg::ST_BREAK: begin
				// Make only after a full cycle with all open
				s_next.st = scan_seq_pkg::ST_SETTLE;
				settleLoad = 1'b1;
				if (nextValid) begin
					s_next.cur = nextIdx;
					s_next.curValid = 1'b1;
					s_next.relays[nextIdx] = 1'b1;
				end
			end
			scan_seq_pkg::ST_SETTLE: begin
				if (settleDone) begin
					// Finite counts step down; zero never ends
					if (s_reg.chanLeft != scan_seq_pkg::COUNT_ONE) begin
						if (s_reg.chanLeft != scan_seq_pkg::COUNT_INF) begin
							s_next.chanLeft = s_reg.chanLeft - 14'h0001;
						end
						s_next.st = scan_seq_pkg::ST_CHAN;
					end else if (s_reg.scanLeft != scan_seq_pkg::COUNT_ONE) begin
						if (s_reg.scanLeft != scan_seq_pkg::COUNT_INF) begin
							s_next.scanLeft = s_reg.scanLeft - 14'h0001;
						end
						s_next.st = scan_seq_pkg::ST_SCAN;
					end else if (s_reg.armLeft != scan_seq_pkg::COUNT_ONE) begin
						if (s_reg.armLeft != scan_seq_pkg::COUNT_INF) begin
							s_next.armLeft = s_reg.armLeft - 14'h0001;
						end
						s_next.st = scan_seq_pkg::ST_ARM;
					end else begin
						s_next.st = scan_seq_pkg::ST_IDLE;
					end
				end
			end
		endcase

		// Abort has the last word over any layer
		if (openAll) begin
			s_next.st = scan_seq_pkg::ST_IDLE;
			s_next.relays = '0;
			s_next.curValid = 1'b0;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Armed is any state but idle
	assign armed = (s_reg.st != scan_seq_pkg::ST_IDLE);
	assign settling = (s_reg.st == scan_seq_pkg::ST_SETTLE);
	assign relayClose = s_reg.relays;
	assign activeChan = s_reg.cur;
	assign scanListQ = s_reg.scanList;
	assign slot0Kind = s_reg.kind0;
	assign slot1Kind = s_reg.kind1;
	assign typeRefused = s_reg.refused;
endmodule

// file: design/scan_seq_pkg.sv
package scan_seq_pkg;
	// Clock and millisecond timebase
	localparam int CLK_PERIOD_NS = 20;
	localparam int TICK_PERIOD_NS = 1000000;
	localparam logic [15:0] TICK_CYCLES =
		16'(TICK_PERIOD_NS / CLK_PERIOD_NS);

	// Loop counts; zero is the reserved infinite code
	localparam int COUNT_W = 14;
	localparam logic [13:0] COUNT_INF = 14'h0000;
	localparam logic [13:0] COUNT_ONE = 14'h0001;
	localparam logic [13:0] COUNT_MAX = 14'h270F;

	// Millisecond delays, up to 99999.999 s
	localparam int MS_W = 27;
	localparam logic [26:0] MS_MAX = 27'h5F5E0FF;
	localparam logic [26:0] MS_ZERO = 27'h0000000;

	// Channel map: two slots of forty relays or crosspoints
	localparam int SLOT_CH = 40;
	localparam int NUM_CH = 80;
	localparam int IDX_W = 7;
	localparam logic [6:0] SLOT1_BASE = 7'h28;
	localparam logic [6:0] IDX_RESET = 7'h00;
	localparam logic [39:0] SLOT_ALL = 40'hFF_FFFF_FFFF;

	// Slot type codes; values arbitrary, not of any real card
	localparam logic [15:0] TYPE_EMPTY = 16'h0000;
	localparam logic [15:0] TYPE_SIM_MUX = 16'h0A01;
	localparam logic [15:0] TYPE_SIM_MATRIX = 16'h0A02;

	typedef enum logic [2:0] {
		SP_IMMEDIATE,
		SP_TIMER,
		SP_EXTERNAL,
		SP_BUS,
		SP_MANUAL,
		trigger_bus_input_spacing,
		SP_HOLD
	} spacing_e;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ARM,
		ST_SCAN,
		ST_CHAN,
		ST_BREAK,
		ST_SETTLE
	} state_e;

	typedef enum logic [1:0] {
		SLOT_EMPTY,
		SLOT_MUX,
		SLOT_MATRIX,
		SLOT_OTHER
	} slot_kind_e;
endpackage

// file: design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [W-1:0] din,
	output logic [W-1:0] level,
	output logic [W-1:0] rise
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] sync;
		logic [W-1:0] last;
	} sync_s;

	sync_s s_reg;
	sync_s s_next;

	// First stage feeds only the second stage
	always_comb begin
		s_next = s_reg;
		s_next.meta = din;
		s_next.sync = s_reg.meta;
		s_next.last = s_reg.sync;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign level = s_reg.sync;
	assign rise = s_reg.sync & ~s_reg.last;
endmodule

// file: design/ms_down_timer.sv
`timescale 1ns/1ps
module ms_down_timer (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic tick,
	input wire logic load,
	input wire logic [26:0] loadVal,
	output logic done
);
	typedef struct packed {
		logic [26:0] count;
	} tmr_s;

	tmr_s s_reg;
	tmr_s s_next;

	// Load wins over a tick in the same cycle
	always_comb begin
		s_next = s_reg;
		if (load) begin
			s_next.count = loadVal;
		end else if (tick && s_reg.count != scan_seq_pkg::MS_ZERO) begin
			s_next.count = s_reg.count - 27'h0000001;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign done = (s_reg.count == scan_seq_pkg::MS_ZERO);
endmodule

// file: verif/scan_seq_assertions.sv
`timescale 1ns/1ps
module scan_seq_checker #(
	parameter logic [15:0] TICK_CYCLES = scan_seq_pkg::TICK_CYCLES
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic stepKey,
	input wire logic busInit,
	input wire logic openAll,
	input wire scan_seq_pkg::spacing_e armSpacing,
	input wire scan_seq_pkg::spacing_e scanSpacing,
	input wire scan_seq_pkg::spacing_e chanSpacing,
	input wire logic [26:0] settleMs0,
	input wire logic [1:0] cardPresent,
	input wire logic typeWr,
	input wire logic typeSlot,
	input wire logic [15:0] typeCode,
	input wire logic armed,
	input wire logic settling,
	input wire logic [79:0] relayClose,
	input wire logic [6:0] activeChan,
	input wire logic [79:0] scanListQ,
	input wire scan_seq_pkg::slot_kind_e slot0Kind,
	input wire scan_seq_pkg::slot_kind_e slot1Kind,
	input wire logic typeRefused
);
	// Pin history, so a type write is judged only on a settled card pin
	logic [5:0] presHist;
	logic [1:0] presOn, presOff;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			presHist <= 6'h00;
		end else begin
			presHist <= {presHist[3:0], cardPresent};
		end
	end
	// Steady high or steady low over four samples
	assign presOn = cardPresent & presHist[1:0] & presHist[3:2] &
		presHist[5:4];
	assign presOff = ~(cardPresent | presHist[1:0] | presHist[3:2] |
		presHist[5:4]);

	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rstn);

	idle_holds_a: assert property (!armed && !busInit && !stepKey &&
		!$past(stepKey) && !$past(stepKey, 2) && !$past(stepKey, 3)
		|=> !armed) else $error("armed rose with no start request");
	start_arms_a: assert property (busInit && !armed && !openAll
		|=> armed) else $error("start request did not arm");
	abort_opens_a: assert property (openAll
		|=> !armed && relayClose == 80'h0) else $error("abort left state");
	break_make_a: assert property (relayClose != 80'h0 &&
		$changed(relayClose) |-> $past(relayClose) == 80'h0)
		else $error("closure without a preceding open");
	settle_time_a: assert property ($rose(settling) &&
		activeChan < 7'h28 && settleMs0 == 27'h2 && TICK_CYCLES == 16'h4
		|-> settling[*6] ##[1:4] !settling)
		else $error("slot0 settle length wrong");
	imm_start_a: assert property (busInit && !armed &&
		{armSpacing, scanSpacing, chanSpacing} == 9'h000 &&
		scanListQ != 80'h0 |-> ##[4:6] (relayClose != 80'h0 &&
		$past(relayClose) == 80'h0)) else $error("first closure late");
	refuse_type_a: assert property (typeWr && presOn[typeSlot]
		|=> typeRefused && $stable(slot0Kind) && $stable(slot1Kind))
		else $error("type write on identified slot not refused");
	sim_mux_a: assert property (typeWr && presOff[typeSlot] &&
		typeCode == scan_seq_pkg::TYPE_SIM_MUX |=> ($past(typeSlot) ?
		slot1Kind : slot0Kind) == scan_seq_pkg::SLOT_MUX)
		else $error("mux simulator code not applied");

	// Main scenarios
	armed_cov: cover property ($rose(armed));
	settle_cov: cover property ($rose(settling));
	refused_cov: cover property (typeRefused);
endmodule

bind scan_trigger_sequencer scan_seq_checker #(.TICK_CYCLES(TICK_CYCLES))
	chk_i (.mclk(mclk), .rstn(rstn), .stepKey(stepKey), .busInit(busInit),
	.openAll(openAll), .armSpacing(armSpacing), .scanSpacing(scanSpacing),
	.chanSpacing(chanSpacing), .settleMs0(settleMs0),
	.cardPresent(cardPresent), .typeWr(typeWr), .typeSlot(typeSlot),
	.typeCode(typeCode), .armed(armed), .settling(settling),
	.relayClose(relayClose), .activeChan(activeChan), .scanListQ(scanListQ),
	.slot0Kind(slot0Kind), .slot1Kind(slot1Kind), .typeRefused(typeRefused));

// file: verif/relay_cards.sv
`timescale 1ns/1ps
module relay_cards (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic [1:0] fitted,
	input wire logic [79:0] relayClose,
	output logic [1:0] cardPresent,
	output logic [15:0] closeCount
);
	logic [79:0] lastClose;
	// Identified-card pins follow what is plugged in
	assign cardPresent = fitted;
	// Only a make after a full break counts, so overlaps go unseen here
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			lastClose <= 80'h0;
			closeCount <= 16'h0000;
		end else begin
			lastClose <= relayClose;
			if (lastClose == 80'h0 && relayClose != 80'h0)
				closeCount <= closeCount + 16'h0001;
		end
	end
endmodule

// file: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic mclk, rstn, stepKey, extTrigIn, trigBusIn, busInit, busTrig;
	logic openAll, chanCountAuto, scanListWr, typeWr, typeSlot;
	logic armed, settling, typeRefused;
	logic [1:0] fitted, cardPresent;
	scan_seq_pkg::spacing_e armSpacing, scanSpacing, chanSpacing;
	logic [13:0] armCount, scanCount, chanCount;
	logic [26:0] scanIntervalMs, chanIntervalMs, settleMs0, settleMs1;
	logic [79:0] scanListData, relayClose, scanListQ;
	logic [15:0] typeCode, closeCount;
	logic [6:0] activeChan;
	scan_seq_pkg::slot_kind_e slot0Kind, slot1Kind;
	int miscompares = 0;
	int checked = 0;
	int total = 0;
	int refusals = 0;
	int cycles = 0;
	int t1;
	int chans[3] = '{2, 5, 41};

	// Short tick keeps millisecond waits cheap
	scan_trigger_sequencer #(.TICK_CYCLES(16'h0004)) scan_trigger_sequencer_i (
		.mclk(mclk), .rstn(rstn), .stepKey(stepKey), .extTrigIn(extTrigIn),
		.trigBusIn(trigBusIn), .cardPresent(cardPresent), .busInit(busInit),
		.busTrig(busTrig), .openAll(openAll), .armSpacing(armSpacing),
		.scanSpacing(scanSpacing), .chanSpacing(chanSpacing),
		.armCount(armCount), .scanCount(scanCount), .chanCount(chanCount),
		.chanCountAuto(chanCountAuto), .scanIntervalMs(scanIntervalMs),
		.chanIntervalMs(chanIntervalMs), .settleMs0(settleMs0),
		.settleMs1(settleMs1), .scanListWr(scanListWr),
		.scanListData(scanListData), .typeWr(typeWr), .typeSlot(typeSlot),
		.typeCode(typeCode), .armed(armed), .settling(settling),
		.relayClose(relayClose), .activeChan(activeChan),
		.scanListQ(scanListQ), .slot0Kind(slot0Kind), .slot1Kind(slot1Kind),
		.typeRefused(typeRefused));
	relay_cards relay_cards_i (.mclk(mclk), .rstn(rstn), .fitted(fitted),
		.relayClose(relayClose), .cardPresent(cardPresent),
		.closeCount(closeCount));

	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Cycle count and refusal pulses
	always @(posedge mclk) begin
		cycles++;
		if (typeRefused === 1'b1)
			refusals++;
	end

	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask
	task automatic chk(input string what, input logic [79:0] exp, got);
		checked++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic give_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Codes 2..5 match the spacing sources; pins held long enough to sync
	task automatic fire(input int src);
		case (src)
		2: extTrigIn = 1'b1;
		3: busTrig = 1'b1;
		4: stepKey = 1'b1;
		5: trigBusIn = 1'b1;
		6: busInit = 1'b1;
		7: openAll = 1'b1;
		8: typeWr = 1'b1;
		default: scanListWr = 1'b1;
		endcase
		cyc((src == 2 || src == 4 || src == 5) ? 3 : 1);
		{extTrigIn, busTrig, stepKey, trigBusIn} = 4'h0;
		{busInit, openAll, typeWr, scanListWr} = 4'h0;
		cyc(3);
	endtask
	task automatic waitClose(input int n);
		int k;
		for (k = 0; k < 400 && closeCount < 16'(n); k++)
			cyc(1);
		if (k == 400) begin
			miscompares++;
			$display("[FAIL] closures expected %0d seen %0d", n, closeCount);
			give_verdict();
		end
	endtask
	task automatic expectNext(input int i);
		total++;
		waitClose(total);
		chk("channel", 80'(chans[i % 3]), 80'(activeChan));
	endtask
	task automatic run(input int n);
		fire(6);
		for (int i = 0; i < n; i++)
			expectNext(i);
		cyc(24);
		chk("armed at end", 80'h0, 80'(armed));
		chk("closures", 80'(total), 80'(closeCount));
	endtask

	initial begin
		{rstn, stepKey, extTrigIn, trigBusIn, busInit, busTrig} = 6'h00;
		{openAll, typeWr, scanListWr, typeSlot, fitted} = 6'h00;
		armSpacing = scan_seq_pkg::SP_IMMEDIATE;
		scanSpacing = scan_seq_pkg::SP_IMMEDIATE;
		chanSpacing = scan_seq_pkg::SP_IMMEDIATE;
		{armCount, scanCount, chanCount} = {3{14'h0001}};
		chanCountAuto = 1'b1;
		{scanIntervalMs, chanIntervalMs} = {27'h0000014, 27'h0000005};
		{settleMs0, settleMs1} = {27'h0000002, 27'h0000003};
		scanListData = 80'h0000_0200_0000_0024;
		typeCode = scan_seq_pkg::TYPE_SIM_MUX;
		cyc(12);
		rstn = 1'b1;
		cyc(2);
		chk("idle armed", 80'h0, 80'(armed));
		fire(8);
		typeSlot = 1'b1;
		typeCode = scan_seq_pkg::TYPE_SIM_MATRIX;
		fire(8);
		chk("kinds", 80'h9, 80'({slot1Kind, slot0Kind}));
		fitted = 2'b10;
		typeCode = scan_seq_pkg::TYPE_SIM_MUX;
		cyc(4);
		fire(8);
		chk("refused", 80'h1, 80'(refusals));
		chk("kinds kept", 80'h9, 80'({slot1Kind, slot0Kind}));
		fitted = 2'b00;
		fire(9);
		chk("scan list", scanListData, scanListQ);
		// Plain, two arms, two scans, programmed channel count
		for (int k = 0; k < 4; k++) begin
			armCount = (k == 1) ? 14'h0002 : 14'h0001;
			scanCount = (k == 2) ? 14'h0002 : 14'h0001;
			chanCountAuto = (k != 3);
			chanCount = 14'h0002;
			run((k == 3) ? 2 : (k == 0) ? 3 : 6);
		end
		// Manual channel stepping with endless count wraps the list
		chanSpacing = scan_seq_pkg::SP_MANUAL;
		{chanCountAuto, chanCount} = 15'h0000;
		fire(4);
		chk("step arms", 80'h1, 80'(armed));
		for (int i = 0; i < 4; i++) begin
			fire(4);
			expectNext(i);
			cyc(20);
			chk("waits for step", 80'(total), 80'(closeCount));
		end
		fire(7);
		chk("abort armed", 80'h0, 80'(armed));
		chk("abort relays", 80'h0, relayClose);
		// Every event source, first at the arm layer, then at the scan layer
		chanSpacing = scan_seq_pkg::SP_IMMEDIATE;
		chanCountAuto = 1'b1;
		for (int s = 2; s < 6; s++) begin
			for (int j = 0; j < 2; j++) begin
				armSpacing = scan_seq_pkg::spacing_e'(j ? 0 : s);
				scanSpacing = scan_seq_pkg::spacing_e'(j ? s : 0);
				fire(6);
				cyc(10);
				chk("held", 80'(total), 80'(closeCount));
				fire(s);
				total += 3;
				waitClose(total);
				cyc(40);
			end
		end
		scanSpacing = scan_seq_pkg::SP_TIMER;
		chanSpacing = scan_seq_pkg::SP_TIMER;
		scanCount = 14'h0002;
		fire(6);
		waitClose(total + 1);
		t1 = cycles;
		waitClose(total + 2);
		chk("chan gap", 80'h1, 80'((cycles - t1) inside {[16:24]}));
		waitClose(total + 4);
		chk("scan gap", 80'h1, 80'((cycles - t1) inside {[76:84]}));
		total += 6;
		waitClose(total);
		cyc(30);
		typeCode = scan_seq_pkg::TYPE_EMPTY;
		fire(8);
		chk("list cleared", 80'h0, scanListQ);
		give_verdict();
	end
endmodule
